// >>> core/ftcr_pkg.sv
package ftcr_pkg;

	// command codes of the configuration registers
	localparam logic [7:0] CMD_FAST_OC = 8'hd1;
	localparam logic [7:0] CMD_TIME_UNITS = 8'hd2;
	localparam logic [7:0] CMD_SCALE_MON = 8'hd3;
	localparam logic [7:0] CMD_SLEW = 8'hd4;
	localparam logic [7:0] CMD_FILTER = 8'hd5;

	// byte counts of each transfer
	localparam logic [3:0] LEN_BYTE = 4'h1;
	localparam logic [3:0] LEN_WORD = 4'h2;
	localparam logic [3:0] LEN_SCALE = 4'h4;
	localparam logic [3:0] LEN_SLEW = 4'h8;

	// fast overcurrent configuration fields
	localparam int OC_EN_BIT = 7;
	localparam int OC_LVL_LSB = 0;
	localparam int OC_LVL_W = 7;
	localparam int OC_CNT_LSB = 8;
	localparam int OC_CNT_W = 5;

	// time-unit selector fields, one per fault class
	localparam int UNIT_W = 2;
	localparam int UNIT_VOUT_LSB = 6;
	localparam int UNIT_VIN_LSB = 4;
	localparam int UNIT_IOUT_LSB = 2;
	localparam int UNIT_TEMP_LSB = 0;
	localparam int NUM_CLASSES = 4;

	// scale monitor and slew limit fields
	localparam int SCALE_ON_LSB = 16;
	localparam int SCALE_OFF_LSB = 0;
	localparam int SLEW_W = 16;
	localparam int VIN_POS_LSB = 48;
	localparam int VIN_NEG_LSB = 32;
	localparam int VOUT_POS_LSB = 16;
	localparam int VOUT_NEG_LSB = 0;

	// reset values
	localparam logic [15:0] RST_FAST_OC = 16'h0000;
	localparam logic [7:0] RST_TIME_UNITS = 8'h00;
	localparam logic [63:0] RST_SLEW = 64'h0000_0000_0000_0000;
	localparam logic [7:0] RST_FILTER = 8'h00;

	// timing: one millisecond at the 100 ns clock
	localparam int CLK_PERIOD_NS = 100;
	localparam int UNIT_1MS_NS = 1000000;
	localparam int MS_CYCLES = UNIT_1MS_NS / CLK_PERIOD_NS;

	// milliseconds per unit for selector values 0..3
	localparam int MULT_W = 10;
	localparam logic [9:0] MULT_1MS = 10'h001;
	localparam logic [9:0] MULT_10MS = 10'h00a;
	localparam logic [9:0] MULT_100MS = 10'h064;
	localparam logic [9:0] MULT_1S = 10'h3e8;

	typedef enum logic [7:0] {
		FILT_OUTPUT_VOLTAGE = 8'h00,
		FILT_OUTPUT_CURRENT = 8'h01,
		FILT_INPUT_FEED_FORWARD = 8'h02
	} ftcr_filter_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] code;
		logic [3:0] len;
		logic [63:0] wdata;
	} ftcr_req_t;

	typedef struct packed {
		logic valid;
		logic nack;
		logic [3:0] len;
		logic [63:0] rdata;
	} ftcr_rsp_t;

endpackage : ftcr_pkg

// >>> core/ftcr_delay_timer.sv
`timescale 1ns/1ps
`default_nettype none
module ftcr_delay_timer #(
	parameter int MS_CYCLES = ftcr_pkg::MS_CYCLES,
	parameter int VALUE_W = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [VALUE_W-1:0] value,
	input wire logic [ftcr_pkg::UNIT_W-1:0] unit_sel,
	output logic busy,
	output logic done
);
	import ftcr_pkg::*;

	localparam int TICK_W = $clog2(MS_CYCLES);
	localparam int TOT_W = VALUE_W + MULT_W;
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(MS_CYCLES - 1);

	if (MS_CYCLES < 2 || VALUE_W < 1) begin : g_chk
		$error("ftcr_delay_timer: bad parameters");
	end

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN = 2'b10
	} ftcr_tstate_t;

	ftcr_tstate_t state, next_state;
	logic [TICK_W-1:0] tick, next_tick;
	logic [TOT_W-1:0] remain, next_remain;
	logic next_done;
	logic [MULT_W-1:0] mult;

	// [R6] unit decode
	always_comb begin
		case (unit_sel)
			2'h0: mult = MULT_1MS;
			2'h1: mult = MULT_10MS;
			2'h2: mult = MULT_100MS;
			default: mult = MULT_1S;
		endcase
	end

	// counts whole milliseconds of value times unit
	always_comb begin
		next_state = state;
		next_tick = tick;
		next_remain = remain;
		next_done = 1'b0;
		case (state)
			ST_IDLE: begin
				if (start) begin
					// [R5] value times unit
					next_remain = TOT_W'(value) * TOT_W'(mult);
					next_tick = '0;
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (remain == '0) begin
					next_done = 1'b1;
					next_state = ST_IDLE;
				end else if (tick == TICK_LAST) begin
					next_tick = '0;
					next_remain = remain - TOT_W'(1);
				end else begin
					next_tick = tick + TICK_W'(1);
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	// timer state registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			tick <= '0;
			remain <= '0;
			done <= 1'b0;
		end else begin
			state <= next_state;
			tick <= next_tick;
			remain <= next_remain;
			done <= next_done;
		end
	end

	assign busy = (state == ST_RUN);

endmodule : ftcr_delay_timer
`default_nettype wire

// >>> core/ftcr_regs.sv
// Contract
// [R1] bit 7 enables fast overcurrent detection
// [R2] bits 12:8 count samples before trip
// [R3] bits 6:0 set the trip level
// [R4] command d1 is read/write word
// [R5] fault time equals value times unit
// [R6] selector: 1 ms, 10 ms, 100 ms, 1 s
// [R7] unit fields: vout, vin, iout, temperature
// [R8] command d3 is read-only four-byte block
// [R9] on-offset high half, off-scale low half
// [R10] input slew within limits for pre-bias
// [R11] output slew within limits for pre-bias
// [R12] filter byte selects coefficient set
// [R13] a low sample clears the run count
`timescale 1ns/1ps
`default_nettype none
module ftcr_regs #(
	parameter int MS_CYCLES = ftcr_pkg::MS_CYCLES,
	parameter int VALUE_W = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire ftcr_pkg::ftcr_req_t req,
	output ftcr_pkg::ftcr_rsp_t rsp,
	input wire logic cur_valid,
	input wire logic [ftcr_pkg::OC_LVL_W-1:0] cur_level,
	output logic overcurrent_protection_on,
	output logic overcurrent_trip,
	input wire logic [ftcr_pkg::NUM_CLASSES-1:0] fault_start,
	input wire logic [ftcr_pkg::NUM_CLASSES*VALUE_W-1:0] fault_value,
	output logic [ftcr_pkg::NUM_CLASSES-1:0] fault_busy,
	output logic [ftcr_pkg::NUM_CLASSES-1:0] fault_done,
	input wire logic [15:0] scale_on_trim,
	input wire logic [15:0] scale_off_trim,
	input wire logic slew_valid,
	input wire logic signed [ftcr_pkg::SLEW_W-1:0] vin_slew,
	input wire logic signed [ftcr_pkg::SLEW_W-1:0] vout_slew,
	output logic prebias_ok,
	output ftcr_pkg::ftcr_filter_t filter_sel
);
	import ftcr_pkg::*;

	if (MS_CYCLES < 2 || VALUE_W < 1 || VALUE_W > 16) begin : g_chk
		$error("ftcr_regs: bad parameters");
	end

	// stored configuration
	logic [15:0] fast_overcurrent_config, next_fast_overcurrent_config;
	logic [7:0] fault_delay_time_units, next_fault_delay_time_units;
	logic [63:0] prestart_slew_limits, next_prestart_slew_limits;
	logic [7:0] filter_coefficient_choice, next_filter_coefficient_choice;
	ftcr_rsp_t next_rsp;

	// request decode helpers
	logic [3:0] exp_len;
	logic known;
	logic refuse;
	logic [63:0] read_word;

	// overcurrent detector state
	logic [OC_CNT_W-1:0] oc_run, next_oc_run;
	logic next_overcurrent_trip;
	logic oc_excess;

	// pre-bias qualification state
	logic next_prebias_ok;
	logic vin_in_window, vout_in_window;

	// field views
	logic oc_enable;
	logic [OC_CNT_W-1:0] oc_samples;
	logic [OC_CNT_W-1:0] oc_target;
	logic [OC_LVL_W-1:0] oc_level;
	logic [UNIT_W-1:0] unit_sel [NUM_CLASSES];
	logic signed [SLEW_W-1:0] vin_pos_lim, vin_neg_lim;
	logic signed [SLEW_W-1:0] vout_pos_lim, vout_neg_lim;

	// [R1] enable bit
	assign oc_enable = fast_overcurrent_config[OC_EN_BIT];
	// [R2] sample count field
	assign oc_samples = fast_overcurrent_config[OC_CNT_LSB +: OC_CNT_W];
	// [R3] trip level field
	assign oc_level = fast_overcurrent_config[OC_LVL_LSB +: OC_LVL_W];
	// a count of zero behaves as one sample
	assign oc_target = (oc_samples == '0) ? OC_CNT_W'(1) : oc_samples;

	// [R7] class field split
	// index 0 vout, 1 vin, 2 iout, 3 temperature
	assign unit_sel[0] = fault_delay_time_units[UNIT_VOUT_LSB +: UNIT_W];
	assign unit_sel[1] = fault_delay_time_units[UNIT_VIN_LSB +: UNIT_W];
	assign unit_sel[2] = fault_delay_time_units[UNIT_IOUT_LSB +: UNIT_W];
	assign unit_sel[3] = fault_delay_time_units[UNIT_TEMP_LSB +: UNIT_W];

	// slew limit fields
	assign vin_pos_lim = prestart_slew_limits[VIN_POS_LSB +: SLEW_W];
	assign vin_neg_lim = prestart_slew_limits[VIN_NEG_LSB +: SLEW_W];
	assign vout_pos_lim = prestart_slew_limits[VOUT_POS_LSB +: SLEW_W];
	assign vout_neg_lim = prestart_slew_limits[VOUT_NEG_LSB +: SLEW_W];

	// refusal decode: unknown code, wrong length, write to the
	// read-only block, or a filter set that does not exist
	always_comb begin
		exp_len = '0;
		known = 1'b1;
		case (req.code)
			CMD_FAST_OC: begin
				// [R4] word transfer
				exp_len = LEN_WORD;
			end
			CMD_TIME_UNITS: begin
				exp_len = LEN_BYTE;
			end
			CMD_SCALE_MON: begin
				// [R8] four-byte block
				exp_len = LEN_SCALE;
			end
			CMD_SLEW: begin
				exp_len = LEN_SLEW;
			end
			CMD_FILTER: begin
				exp_len = LEN_BYTE;
			end
			default: begin
				known = 1'b0; // unknown command
			end
		endcase
		// length must match the transfer size of the command
		refuse = !known || (req.len != exp_len);
		// [R8] read-only block
		if (req.write && req.code == CMD_SCALE_MON) begin
			refuse = 1'b1;
		end
		// [R12] only defined sets
		if (req.write && req.code == CMD_FILTER
			&& req.wdata[7:0] > FILT_INPUT_FEED_FORWARD) begin
			refuse = 1'b1;
		end
	end

	// read data of each register, low bits first, upper bits zero
	always_comb begin
		read_word = '0;
		case (req.code)
			CMD_FAST_OC: begin
				read_word[15:0] = fast_overcurrent_config;
			end
			CMD_TIME_UNITS: begin
				read_word[7:0] = fault_delay_time_units;
			end
			CMD_SCALE_MON: begin
				// [R9] on high, off low
				read_word[SCALE_ON_LSB +: 16] = scale_on_trim;
				read_word[SCALE_OFF_LSB +: 16] = scale_off_trim;
			end
			CMD_SLEW: begin
				read_word = prestart_slew_limits;
			end
			CMD_FILTER: begin
				read_word[7:0] = filter_coefficient_choice;
			end
			default: begin
				read_word = '0;
			end
		endcase
	end

	// write decode and answer; a refused request changes nothing
	always_comb begin
		next_fast_overcurrent_config = fast_overcurrent_config;
		next_fault_delay_time_units = fault_delay_time_units;
		next_prestart_slew_limits = prestart_slew_limits;
		next_filter_coefficient_choice = filter_coefficient_choice;
		next_rsp = '0;
		if (req.valid) begin
			next_rsp.valid = 1'b1;
			next_rsp.nack = refuse;
			next_rsp.len = req.len;
			if (refuse) begin
				next_rsp.rdata = '0;
			end else if (req.write) begin
				// a write answers with zero data
				case (req.code)
					CMD_FAST_OC: begin
						next_fast_overcurrent_config = req.wdata[15:0];
					end
					CMD_TIME_UNITS: begin
						next_fault_delay_time_units = req.wdata[7:0];
					end
					CMD_SLEW: begin
						next_prestart_slew_limits = req.wdata;
					end
					CMD_FILTER: begin
						next_filter_coefficient_choice = req.wdata[7:0];
					end
					default: begin
						next_rsp.rdata = '0;
					end
				endcase
			end else begin
				next_rsp.rdata = read_word;
			end
		end
	end

	// configuration and answer registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fast_overcurrent_config <= RST_FAST_OC;
			fault_delay_time_units <= RST_TIME_UNITS;
			prestart_slew_limits <= RST_SLEW;
			filter_coefficient_choice <= RST_FILTER;
			rsp <= '0;
		end else begin
			fast_overcurrent_config <= next_fast_overcurrent_config;
			fault_delay_time_units <= next_fault_delay_time_units;
			prestart_slew_limits <= next_prestart_slew_limits;
			filter_coefficient_choice <= next_filter_coefficient_choice;
			rsp <= next_rsp;
		end
	end

	// [R3] sample at or above the trip level
	assign oc_excess = (cur_level >= oc_level);

	// run counter of consecutive excess samples
	always_comb begin
		next_oc_run = oc_run;
		next_overcurrent_trip = 1'b0;
		if (!oc_enable) begin
			// [R1] disabled clears detector
			next_oc_run = '0;
		end else if (cur_valid) begin
			if (oc_excess) begin
				// [R2] trip at count
				if (oc_run < oc_target) begin
					next_oc_run = oc_run + OC_CNT_W'(1);
					next_overcurrent_trip = (next_oc_run == oc_target);
				end
			end else begin
				// [R13] low sample clears
				next_oc_run = '0;
			end
		end
	end

	// detector registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			oc_run <= '0;
			overcurrent_trip <= 1'b0;
		end else begin
			oc_run <= next_oc_run;
			overcurrent_trip <= next_overcurrent_trip;
		end
	end

	// [R1] enable state shown to the power stage
	assign overcurrent_protection_on = oc_enable;

	// [R10] input slew window, limits inclusive
	assign vin_in_window = (vin_slew <= vin_pos_lim)
		&& (vin_slew >= vin_neg_lim);
	// [R11] output slew window, limits inclusive
	assign vout_in_window = (vout_slew <= vout_pos_lim)
		&& (vout_slew >= vout_neg_lim);

	// pre-bias verdict, held until the next slew measurement
	always_comb begin
		next_prebias_ok = prebias_ok;
		if (slew_valid) begin
			next_prebias_ok = vin_in_window && vout_in_window;
		end
	end

	// pre-bias register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prebias_ok <= 1'b0;
		end else begin
			prebias_ok <= next_prebias_ok;
		end
	end

	// [R12] coefficient set output
	assign filter_sel = ftcr_filter_t'(filter_coefficient_choice);

	// one delay timer per fault class
	for (genvar i = 0; i < NUM_CLASSES; i++) begin : g_cls
		// [R5] scaled fault timer
		ftcr_delay_timer #(
			.MS_CYCLES(MS_CYCLES),
			.VALUE_W(VALUE_W)
		) u_timer (
			.clk(clk),
			.rst_n(rst_n),
			.start(fault_start[i]),
			.value(fault_value[i*VALUE_W +: VALUE_W]),
			.unit_sel(unit_sel[i]),
			.busy(fault_busy[i]),
			.done(fault_done[i])
		);
	end

endmodule : ftcr_regs
`default_nettype wire

// >>> testbench/ftcr_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ftcr_regs_chk
	import ftcr_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire ftcr_pkg::ftcr_req_t req,
	input wire ftcr_pkg::ftcr_rsp_t rsp,
	input wire logic cur_valid,
	input wire logic overcurrent_protection_on,
	input wire logic overcurrent_trip,
	input wire logic [3:0] fault_busy,
	input wire logic [3:0] fault_done,
	input wire logic [15:0] scale_on_trim,
	input wire logic [15:0] scale_off_trim,
	input wire logic slew_valid,
	input wire logic prebias_ok,
	input wire ftcr_pkg::ftcr_filter_t filter_sel
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// register port answers
	a_req_answered: assert property (req.valid |=> rsp.valid) // answer
		else $error("request not answered");
	a_rsp_has_req: assert property (rsp.valid |-> $past(req.valid))
		else $error("answer without request");
	a_scale_ro: assert property (req.valid && req.write && // read only
		req.code == CMD_SCALE_MON |=> rsp.nack)
		else $error("scale monitor write accepted");
	a_scale_data: assert property (req.valid && !req.write && // halves
		req.code == CMD_SCALE_MON && req.len == LEN_SCALE |=>
		rsp.rdata == {32'h0, $past(scale_on_trim), $past(scale_off_trim)})
		else $error("scale monitor data wrong");
	// detector behaviour
	a_oc_off_quiet: assert property (!overcurrent_protection_on |=>
		!overcurrent_trip)
		else $error("trip while disabled");
	a_trip_single: assert property (overcurrent_trip |=> // one pulse
		!overcurrent_trip)
		else $error("trip repeated");
	a_trip_sample: assert property (overcurrent_trip |-> // sample
		$past(cur_valid))
		else $error("trip without sample");
	// timer, filter and pre-bias outputs
	a_done_busy: assert property (fault_done[0] |-> // end of wait
		$past(fault_busy[0]) && !fault_busy[0])
		else $error("done without busy");
	a_filter_legal: assert property (filter_sel <= // legal set
		FILT_INPUT_FEED_FORWARD)
		else $error("filter set out of range");
	a_prebias_hold: assert property (!$past(slew_valid) |-> // held
		$stable(prebias_ok))
		else $error("pre-bias verdict moved");
	c_trip: cover property (overcurrent_trip);
	c_done: cover property (fault_done[3]);
	c_nack: cover property (rsp.valid && rsp.nack);
	c_prebias: cover property ($rose(prebias_ok));
endmodule : ftcr_regs_chk
bind ftcr_regs ftcr_regs_chk u_ftcr_regs_chk(.clk(clk), .rst_n(rst_n),
	.req(req), .rsp(rsp), .cur_valid(cur_valid),
	.overcurrent_protection_on(overcurrent_protection_on),
	.overcurrent_trip(overcurrent_trip), .fault_busy(fault_busy),
	.fault_done(fault_done), .scale_on_trim(scale_on_trim),
	.scale_off_trim(scale_off_trim), .slew_valid(slew_valid),
	.prebias_ok(prebias_ok), .filter_sel(filter_sel));
`default_nettype wire

// >>> testbench/ftcr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ftcr_host_model
	import ftcr_pkg::*;
(
	input wire logic clk,
	output ftcr_pkg::ftcr_req_t req,
	input wire ftcr_pkg::ftcr_rsp_t rsp
);
	initial req = '0;
	task automatic xfer(input logic w, input logic [7:0] c,
		input logic [3:0] n, input logic [63:0] d, output ftcr_rsp_t r);
		@(negedge clk);
		req <= '{1'b1, w, c, n, d};
		@(negedge clk);
		// the answer stands for one cycle after the request edge
		r = rsp;
		// released lines show the inverse, not the old value
		req <= '{1'b0, ~w, ~c, ~n, ~d};
	endtask : xfer
endmodule : ftcr_host_model
`default_nettype wire

// >>> testbench/test_fault_timing_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_fault_timing_config_regs;
	import ftcr_pkg::*;
	localparam int MSC = 4;
	logic clk = 0, rst_n = 0, cur_valid = 0, slew_valid = 0;
	logic [6:0] cur_level = '0;
	logic [3:0] fault_start = '0, fault_busy, fault_done;
	logic [31:0] fault_value = '0;
	logic [15:0] scale_on_trim = '0, scale_off_trim = '0;
	logic signed [15:0] vin_slew = '0, vout_slew = '0;
	logic overcurrent_protection_on, overcurrent_trip, prebias_ok;
	ftcr_req_t req;
	ftcr_rsp_t rsp, r;
	ftcr_filter_t filter_sel;
	int miscompares = 0, n_checks = 0;
	logic [63:0] v;
	always #50 clk = ~clk;
	ftcr_host_model u_ftcr_host_model(.clk(clk), .req(req), .rsp(rsp));
	ftcr_regs #(.MS_CYCLES(MSC), .VALUE_W(8)) u_ftcr_regs(.clk(clk),
		.rst_n(rst_n), .req(req), .rsp(rsp), .cur_valid(cur_valid),
		.cur_level(cur_level), .overcurrent_trip(overcurrent_trip),
		.overcurrent_protection_on(overcurrent_protection_on),
		.fault_start(fault_start), .fault_value(fault_value),
		.fault_busy(fault_busy), .fault_done(fault_done),
		.scale_on_trim(scale_on_trim), .scale_off_trim(scale_off_trim),
		.slew_valid(slew_valid), .vin_slew(vin_slew),
		.vout_slew(vout_slew), .prebias_ok(prebias_ok),
		.filter_sel(filter_sel));
	task automatic chk(input logic [63:0] g, e);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] c, input logic [3:0] l,
		input logic [63:0] d, input logic nk);
		u_ftcr_host_model.xfer(1'b1, c, l, d, r);
		chk({r.valid, r.nack, r.len}, {1'b1, nk, l}); // answer
	endtask : wr
	task automatic rd(input logic [7:0] c, input logic [3:0] l,
		input logic [63:0] e);
		u_ftcr_host_model.xfer(1'b0, c, l, 64'h0, r);
		chk({r.valid, r.nack, r.len}, {2'b10, l}); // answer
		chk(r.rdata, e); // read data
	endtask : rd
	function automatic int ms(input logic [1:0] u);
		return u == 0 ? 1 : u == 1 ? 10 : u == 2 ? 100 : 1000;
	endfunction : ms
	task automatic smp(input logic [6:0] l, input logic e);
		@(negedge clk);
		cur_valid = 1;
		cur_level = l;
		@(negedge clk);
		cur_valid = 0;
		chk(overcurrent_trip, e); // trip pulse
	endtask : smp
	task automatic slw(input logic signed [15:0] a, b);
		@(negedge clk);
		slew_valid = 1;
		vin_slew = a;
		vout_slew = b;
		@(negedge clk);
		slew_valid = 0;
		@(negedge clk);
		chk(prebias_ok, a >= -100 && a <= 100 && b >= -50 && b <= 50);
	endtask : slw
	task automatic tmr(input int i, input logic [7:0] x, input logic [1:0] u);
		int n;
		@(negedge clk);
		fault_start[i] = 1;
		fault_value[i*8 +: 8] = x;
		@(negedge clk);
		fault_start[i] = 0;
		chk(fault_busy[i], 1'b1); // busy
		n = 1;
		while (fault_done[i] !== 1'b1 && n < 9000) begin
			@(negedge clk);
			n++;
		end
		chk(n, x * ms(u) * MSC + 2); // wait length
	endtask : tmr
	task automatic final_report();
		if (miscompares == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : final_report
	// watchdog well beyond the longest run
	initial begin
		#(100 * 100000);
		miscompares++;
		final_report();
	end
	// main sequence
	initial begin
		v = 64'($urandom(32'he15b));
		repeat (5) @(negedge clk);
		rst_n = 1;
		rd(CMD_FAST_OC, LEN_WORD, 0); // word read
		wr(CMD_SCALE_MON, LEN_SCALE, 0, 1); // write refused
		wr(CMD_FAST_OC, LEN_BYTE, 0, 1); // bad length
		wr(CMD_FILTER, LEN_BYTE, 3, 1); // bad set
		for (int i = 0; i < 3; i++) begin
			wr(CMD_FILTER, LEN_BYTE, i, 0); // set write
			chk(filter_sel, i); // set used
		end
		scale_on_trim = 16'($urandom);
		scale_off_trim = 16'($urandom);
		rd(CMD_SCALE_MON, LEN_SCALE, {scale_on_trim, scale_off_trim});
		v = {$urandom, $urandom};
		wr(CMD_SLEW, LEN_SLEW, v, 0); // block write
		rd(CMD_SLEW, LEN_SLEW, v); // block read
		v = 64'h0064_ff9c_0032_ffce;
		wr(CMD_SLEW, LEN_SLEW, v, 0); // limits
		slw(100, 50); // edge inside
		slw(101, 0); // too fast
		slw(0, -51); // too fast
		slw(-100, -50); // edge inside
		repeat (8) slw(16'($urandom_range(0, 300) - 150),
			16'($urandom_range(0, 200) - 100)); // random
		v = 64'($urandom & 32'h1fff);
		wr(CMD_FAST_OC, LEN_WORD, v, 0); // word write
		rd(CMD_FAST_OC, LEN_WORD, v); // readback
		wr(CMD_FAST_OC, LEN_WORD, 16'h03a0, 0); // three samples
		chk(overcurrent_protection_on, 1); // enabled
		smp(7'h20, 0); // first sample
		smp(7'h7f, 0); // second sample
		smp(7'h1f, 0); // run cleared
		smp(7'h20, 0); // first again
		smp(7'h30, 0); // second sample
		smp(7'h20, 1); // third sample
		smp(7'h40, 0); // no repeat
		v = 64'($urandom_range(1, 127));
		wr(CMD_FAST_OC, LEN_WORD, {8'h01, 1'b1, v[6:0]}, 0); // level
		smp(v[6:0] - 7'h1, 0); // below level
		smp(v[6:0], 1); // at level
		wr(CMD_FAST_OC, LEN_WORD, 16'h0120, 0); // disable
		smp(7'h7f, 0); // no trip
		chk(overcurrent_protection_on, 0); // disabled
		for (int j = 0; j < 2; j++) begin
			v = j ? 8'he4 : 8'h1b;
			wr(CMD_TIME_UNITS, LEN_BYTE, v, 0); // all units
			rd(CMD_TIME_UNITS, LEN_BYTE, v); // readback
			for (int i = 0; i < 4; i++) begin
				tmr(i, 8'($urandom_range(0, 2)), v[7-2*i -: 2]);
			end
		end
		final_report();
	end
endmodule : test_fault_timing_config_regs
`default_nettype wire
